// File: rtl/epc_defs.svh
// Constants for the EEPROM program/erase controller
// =====================================================================
// Notes on behaviour
// - Self-timed mode: internal timer ends cycle and clears prog_en itself.
// - While latched, only writes to valid EEPROM addresses are captured.
// - Later valid writes replace earlier captured address and data.
// - Latched EEPROM read returns captured data and captures the read address.
// - Setting prog_en is ignored without latch_en or a captured address.
// - Clearing latch_en and prog_en together clears only prog_en.
// - latch_en cannot be cleared while prog_en is set.
// - erase_sel picks program, byte, block or bulk erase; locked block does nothing.
// - array_off powers the array down; reset clears it.
// - Reset clears prog_en, latch_en and erase select.
// - prog_en drives the charge pump only when latched with a captured write.
// - After reset the config byte is copied into array config; only its spare bits are writable.
// - secure_n low enables security, which can never be turned off.
// - Four block_lock bits protect 128-byte blocks, bit 0 lowest.
// - Secured: byte operations only, top sixteen bytes of block 1 frozen.
// - Config byte is programmed and erased like an array byte; factory unprotected.
// - 11-bit divisor over two registers, loaded from copies at reset.
// - divider_unlock low locks divider registers and their nonvolatile copies.
// - Divider always readable; writable only with latch_en low, unlock high.
// - Program only clears bits; erase sets bits to one.
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH
`define EPC_ARRAY_BASE      16'h0800
`define EPC_ARRAY_LAST      16'h09ff
`define EPC_ADDR_CTRL       16'h0040
`define EPC_ADDR_ACFG       16'h0041
`define EPC_ADDR_DIVH       16'h0042
`define EPC_ADDR_DIVL       16'h0043
`define EPC_ADDR_STAT       16'h0044
`define EPC_ADDR_ACFG_NV    16'h0a00
`define EPC_ADDR_DIVH_NV    16'h0a01
`define EPC_ADDR_DIVL_NV    16'h0a02
`define EPC_SECURED_ROW     5'h0f
`define EPC_ERASED          8'hff
`define EPC_ACFG_FACTORY    8'hf0
`define EPC_DIVH_FACTORY    8'h80
`define EPC_DIVL_FACTORY    8'h01
`define EPC_STAT_CLR_BIT    1
`define EPC_TIMEBASE_US     35
`define EPC_PROGRAM_US      10000
`define EPC_BYTE_ERASE_US   10000
`define EPC_BLOCK_ERASE_US  10000
`define EPC_BULK_ERASE_US   10000
`define EPC_PROGRAM_TICKS   (`EPC_PROGRAM_US / `EPC_TIMEBASE_US)
`define EPC_BYTE_TICKS      (`EPC_BYTE_ERASE_US / `EPC_TIMEBASE_US)
`define EPC_BLOCK_TICKS     (`EPC_BLOCK_ERASE_US / `EPC_TIMEBASE_US)
`define EPC_BULK_TICKS      (`EPC_BULK_ERASE_US / `EPC_TIMEBASE_US)
`endif

// File: rtl/epc_pkg.sv
// Types of the EEPROM program/erase controller
package epc_pkg;
  typedef enum logic [1:0] {EPC_PROG, EPC_BYTE_ER, EPC_BLOCK_ER, EPC_BULK_ER} epc_mode_t;
  typedef enum logic [1:0] {EPC_BOOT, EPC_READY, EPC_TIMED} epc_phase_t;
  typedef struct packed {
    logic [1:0] spare;
    logic       array_off;
    epc_mode_t  erase_sel;
    logic       latch_en;
    logic       self_timed_end;
    logic       prog_en;
  } epc_ctrl_t;
  typedef struct packed {
    logic [2:0] spare;
    logic       secure_n;
    logic [3:0] block_lock;
  } epc_acfg_t;
  typedef struct packed {
    logic       divider_unlock;
    logic [3:0] zero;
    logic [2:0] div_hi;
  } epc_divh_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } epc_req_t;
  typedef struct packed {
    epc_phase_t  phase;
    epc_ctrl_t   ctrl;
    epc_acfg_t   acfg;
    epc_divh_t   divh;
    logic [7:0]  divl;
    logic [15:0] cap_addr;
    logic [7:0]  cap_data;
    logic        captured;
    logic        disturbed;
    logic        pump;
    logic [10:0] tb_cnt;
    logic [15:0] op_ticks;
    logic [1:0]  ref_sync;
    logic        ref_prev;
    logic [7:0]  rdata;
  } epc_vol_t;
  typedef struct packed {
    logic [7:0]           acfg_nv;
    logic [7:0]           divh_nv;
    logic [7:0]           divl_nv;
    logic [511:0][7:0]    mem;
  } epc_nv_t;
endpackage

// File: rtl/epc_ctrl.sv
// EEPROM program/erase controller with array and nonvolatile bytes
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "epc_defs.svh"
module epc_ctrl (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              por_n_in,
  input  wire logic              ref_sel_in,
  input  wire logic              ref_clk_in,
  input  wire epc_pkg::epc_req_t bus_in,
  output logic [7:0]             rdata_out,
  output logic                   pump_on_out,
  output logic                   power_down_out
);
  import epc_pkg::*;

  // ===================================================================
  // Helpers
  // ===================================================================

  // Protection check for the captured target
  function automatic logic epc_allowed(
    input logic [15:0] a,
    input epc_mode_t   m,
    input epc_acfg_t   c,
    input epc_divh_t   d,
    input logic        nv_sec_n
  );
    logic [8:0] off;
    logic       ok;
    off = 9'(a - `EPC_ARRAY_BASE);
    ok = 1'b1;
    if (a == `EPC_ADDR_ACFG_NV)
    begin
      // Once a zero reaches the stored bit the byte is frozen
      ok = c.secure_n & nv_sec_n;
    end
    else if (a == `EPC_ADDR_DIVH_NV || a == `EPC_ADDR_DIVL_NV)
    begin
      ok = d.divider_unlock;
    end
    else
    begin
      if (c.block_lock[off[8:7]])
      begin
        ok = 1'b0;
      end
      if (!c.secure_n && off[8:4] == `EPC_SECURED_ROW)
      begin
        ok = 1'b0;
      end
      if (!c.secure_n && (m == EPC_BLOCK_ER || m == EPC_BULK_ER))
      begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Self-timed length in timebase ticks
  function automatic logic [15:0] epc_limit(input epc_mode_t m);
    logic [15:0] t;
    t = 16'h0000;
    unique case (m)
      EPC_PROG:     t = 16'(`EPC_PROGRAM_TICKS);
      EPC_BYTE_ER:  t = 16'(`EPC_BYTE_TICKS);
      EPC_BLOCK_ER: t = 16'(`EPC_BLOCK_TICKS);
      EPC_BULK_ER:  t = 16'(`EPC_BULK_TICKS);
    endcase
    return t;
  endfunction

  // ===================================================================
  // State and decode
  // ===================================================================

  epc_vol_t    st;
  epc_vol_t    next_st;
  epc_nv_t     nvs;
  epc_nv_t     next_nvs;

  logic        hit_array;
  logic        hit_nv;
  logic        hit_valid;
  logic [8:0]  bus_off;
  logic [8:0]  cap_off;

  // Address classes
  assign hit_array = (bus_in.addr >= `EPC_ARRAY_BASE) && (bus_in.addr <= `EPC_ARRAY_LAST);
  assign hit_nv    = (bus_in.addr == `EPC_ADDR_ACFG_NV) ||
                     (bus_in.addr == `EPC_ADDR_DIVH_NV) ||
                     (bus_in.addr == `EPC_ADDR_DIVL_NV);
  assign hit_valid = hit_array | hit_nv;
  assign bus_off   = 9'(bus_in.addr - `EPC_ARRAY_BASE);
  assign cap_off   = 9'(st.cap_addr - `EPC_ARRAY_BASE);

  // ===================================================================
  // Next state
  // ===================================================================

  always_comb
  begin
    epc_ctrl_t   wc;
    logic        ref_edge;
    logic        src_tick;
    logic        tick;
    logic [10:0] divisor;
    logic        start;
    logic        stop;
    logic        auto_done;
    logic        done;
    logic [7:0]  old;
    logic [7:0]  nv_new;
    next_st = st;
    next_nvs = nvs;
    wc = epc_ctrl_t'(bus_in.wdata);
    start = 1'b0;
    stop = 1'b0;
    auto_done = 1'b0;
    tick = 1'b0;
    old = 8'h00;
    nv_new = 8'h00;
    next_st.rdata = 8'h00;

    // Reference edge; only the second stage is looked at
    next_st.ref_sync = {st.ref_sync[0], ref_clk_in};
    next_st.ref_prev = st.ref_sync[1];
    ref_edge = st.ref_sync[1] & ~st.ref_prev;
    src_tick = ref_sel_in ? ref_edge : 1'b1;

    // Timebase divider; a zero divisor ticks every source cycle
    divisor = {st.divh.div_hi, st.divl};
    if (src_tick)
    begin
      if (st.tb_cnt + 11'h001 >= divisor)
      begin
        next_st.tb_cnt = 11'h000;
        tick = 1'b1;
      end
      else
      begin
        next_st.tb_cnt = st.tb_cnt + 11'h001;
      end
    end

    if (st.phase == EPC_BOOT)
    begin
      // Copy nonvolatile settings one cycle after reset release
      next_st.acfg = epc_acfg_t'(nvs.acfg_nv);
      next_st.divh = epc_divh_t'(nvs.divh_nv);
      next_st.divh.zero = 4'h0;
      next_st.divl = nvs.divl_nv;
      next_st.phase = EPC_READY;
    end
    else if (bus_in.wr)
    begin
      if (hit_valid)
      begin
        // Captures are frozen while the pump runs
        if (st.ctrl.latch_en && !st.ctrl.prog_en && !st.ctrl.array_off)
        begin
          next_st.cap_addr = bus_in.addr;
          next_st.cap_data = bus_in.wdata;
          next_st.captured = 1'b1;
        end
      end
      else if (bus_in.addr == `EPC_ADDR_CTRL)
      begin
        if (st.ctrl.latch_en && !st.captured)
        begin
          // Before a capture only dropping the latch is accepted
          next_st.ctrl.latch_en = wc.latch_en;
        end
        else
        begin
          next_st.ctrl.spare = wc.spare;
          next_st.ctrl.array_off = wc.array_off;
          next_st.ctrl.self_timed_end = wc.self_timed_end;
          if (!st.ctrl.prog_en)
          begin
            next_st.ctrl.erase_sel = wc.erase_sel;
          end
          next_st.ctrl.latch_en = wc.latch_en | st.ctrl.prog_en;
          start = wc.prog_en & ~st.ctrl.prog_en & st.ctrl.latch_en &
                  st.captured & ~st.ctrl.array_off;
          stop = ~wc.prog_en & st.ctrl.prog_en;
        end
      end
      else if (bus_in.addr == `EPC_ADDR_ACFG)
      begin
        // Only the spare bits are writable here
        next_st.acfg.spare = bus_in.wdata[7:5];
      end
      else if (bus_in.addr == `EPC_ADDR_DIVH)
      begin
        if (!st.ctrl.latch_en && st.divh.divider_unlock)
        begin
          next_st.divh.divider_unlock = bus_in.wdata[7];
          next_st.divh.div_hi = bus_in.wdata[2:0];
        end
      end
      else if (bus_in.addr == `EPC_ADDR_DIVL)
      begin
        if (!st.ctrl.latch_en && st.divh.divider_unlock)
        begin
          next_st.divl = bus_in.wdata;
        end
      end
      else if (bus_in.addr == `EPC_ADDR_STAT)
      begin
        if (bus_in.wdata[`EPC_STAT_CLR_BIT])
        begin
          next_st.disturbed = 1'b0;
        end
      end
    end
    else if (bus_in.rd)
    begin
      if (hit_valid && st.ctrl.latch_en)
      begin
        // Latched reads echo the capture and move its address
        next_st.rdata = st.cap_data;
        next_st.cap_addr = bus_in.addr;
        if (st.ctrl.prog_en)
        begin
          next_st.disturbed = 1'b1;
        end
      end
      else if (hit_valid && st.ctrl.array_off)
      begin
        // Powered-down array gives no useful data
        next_st.rdata = `EPC_ERASED;
      end
      else if (hit_array)
      begin
        next_st.rdata = nvs.mem[bus_off];
      end
      else if (bus_in.addr == `EPC_ADDR_ACFG_NV)
      begin
        next_st.rdata = nvs.acfg_nv;
        // Reading the stored byte refreshes block protection
        next_st.acfg.block_lock = nvs.acfg_nv[3:0];
      end
      else if (bus_in.addr == `EPC_ADDR_DIVH_NV)
      begin
        next_st.rdata = nvs.divh_nv;
      end
      else if (bus_in.addr == `EPC_ADDR_DIVL_NV)
      begin
        next_st.rdata = nvs.divl_nv;
      end
      else if (bus_in.addr == `EPC_ADDR_CTRL)
      begin
        next_st.rdata = st.ctrl;
      end
      else if (bus_in.addr == `EPC_ADDR_ACFG)
      begin
        next_st.rdata = st.acfg;
      end
      else if (bus_in.addr == `EPC_ADDR_DIVH)
      begin
        next_st.rdata = st.divh;
      end
      else if (bus_in.addr == `EPC_ADDR_DIVL)
      begin
        next_st.rdata = st.divl;
      end
      else if (bus_in.addr == `EPC_ADDR_STAT)
      begin
        next_st.rdata = {6'h00, st.disturbed, st.pump};
      end
    end

    // Self-timed termination counts timebase ticks
    if (st.phase == EPC_TIMED && tick)
    begin
      next_st.op_ticks = st.op_ticks + 16'h0001;
      if (st.op_ticks + 16'h0001 >= epc_limit(st.ctrl.erase_sel))
      begin
        auto_done = 1'b1;
      end
    end
    done = stop | auto_done;

    if (start)
    begin
      next_st.ctrl.prog_en = 1'b1;
      next_st.pump = 1'b1;
      next_st.disturbed = 1'b0;
      next_st.tb_cnt = 11'h000;
      next_st.op_ticks = 16'h0000;
      next_st.phase = next_st.ctrl.self_timed_end ? EPC_TIMED : EPC_READY;
    end
    else if (done)
    begin
      // Latch stays set; software drops it after the voltage falls
      next_st.ctrl.prog_en = 1'b0;
      next_st.pump = 1'b0;
      next_st.phase = EPC_READY;
      if (!st.disturbed && !next_st.disturbed &&
          epc_allowed(st.cap_addr, st.ctrl.erase_sel, st.acfg, st.divh, nvs.acfg_nv[4]))
      begin
        if (st.cap_addr == `EPC_ADDR_ACFG_NV ||
            st.cap_addr == `EPC_ADDR_DIVH_NV ||
            st.cap_addr == `EPC_ADDR_DIVL_NV)
        begin
          // Stored settings behave like single array bytes
          if (st.cap_addr == `EPC_ADDR_ACFG_NV)
          begin
            old = nvs.acfg_nv;
          end
          else if (st.cap_addr == `EPC_ADDR_DIVH_NV)
          begin
            old = nvs.divh_nv;
          end
          else
          begin
            old = nvs.divl_nv;
          end
          nv_new = (st.ctrl.erase_sel == EPC_PROG) ? (old & st.cap_data)
                                                  : `EPC_ERASED;
          if (st.cap_addr == `EPC_ADDR_ACFG_NV)
          begin
            next_nvs.acfg_nv = nv_new;
          end
          else if (st.cap_addr == `EPC_ADDR_DIVH_NV)
          begin
            next_nvs.divh_nv = nv_new;
          end
          else
          begin
            next_nvs.divl_nv = nv_new;
          end
        end
        else
        begin
          unique case (st.ctrl.erase_sel)
            EPC_PROG:
            begin
              // Bits only fall; a zero in memory stays zero
              next_nvs.mem[cap_off] = nvs.mem[cap_off] & st.cap_data;
            end
            EPC_BYTE_ER:
            begin
              next_nvs.mem[cap_off] = `EPC_ERASED;
            end
            EPC_BLOCK_ER:
            begin
              for (int i = 0; i < 512; i++)
              begin
                if (9'(i) >> 7 == cap_off >> 7)
                begin
                  next_nvs.mem[i] = `EPC_ERASED;
                end
              end
            end
            EPC_BULK_ER:
            begin
              // Locked blocks survive a bulk erase
              for (int i = 0; i < 512; i++)
              begin
                if (!st.acfg.block_lock[2'(i >> 7)])
                begin
                  next_nvs.mem[i] = `EPC_ERASED;
                end
              end
            end
          endcase
        end
      end
    end

    // Dropping the latch forgets the capture
    if (!next_st.ctrl.latch_en)
    begin
      next_st.captured = 1'b0;
    end
  end

  // ===================================================================
  // Registers
  // ===================================================================

  // Volatile state; boot phase reloads settings after release
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Nonvolatile storage survives system reset, factory state at power-on
  always_ff @(posedge clk_in or negedge por_n_in)
  begin
    if (!por_n_in)
    begin
      nvs.acfg_nv <= `EPC_ACFG_FACTORY;
      nvs.divh_nv <= `EPC_DIVH_FACTORY;
      nvs.divl_nv <= `EPC_DIVL_FACTORY;
      nvs.mem <= '1;
    end
    else
    begin
      nvs <= next_nvs;
    end
  end

  // Outputs straight from state
  assign rdata_out      = st.rdata;
  assign pump_on_out    = st.pump;
  assign power_down_out = st.ctrl.array_off;

endmodule

// File: tb/epc_ctrl_checker.sv
// Port-level assertions for the EEPROM program/erase controller
`timescale 1ns/1ps
`include "epc_defs.svh"
module epc_ctrl_checker (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              por_n_in,
  input  wire logic              ref_sel_in,
  input  wire logic              ref_clk_in,
  input  wire epc_pkg::epc_req_t bus_in,
  input  wire logic [7:0]        rdata_out,
  input  wire logic              pump_on_out,
  input  wire logic              power_down_out
);
  import epc_pkg::*;
  localparam int AUTO_MIN = 280;
  logic        ctrl_wr;
  logic        start_req;
  logic        ctrl_rd_on;
  logic        auto_q;
  logic [15:0] on_cnt;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ====
  // Helpers
  // Decodes shared by several properties
  assign ctrl_wr    = bus_in.wr && (bus_in.addr == `EPC_ADDR_CTRL);
  assign start_req  = ctrl_wr && bus_in.wdata[0] && !power_down_out;
  assign ctrl_rd_on = pump_on_out && bus_in.rd && (bus_in.addr == `EPC_ADDR_CTRL);
  // Timed flag taken at start, since a timed cycle may end with no write
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      auto_q <= 1'b0;
      on_cnt <= 16'h0000;
    end
    else
    begin
      if (ctrl_wr && !pump_on_out)
        auto_q <= bus_in.wdata[1];
      on_cnt <= pump_on_out ? on_cnt + 16'h0001 : 16'h0000;
    end
  end
  sequence s_stop_req;
    pump_on_out && ctrl_wr && !bus_in.wdata[0];
  endsequence
  sequence s_idle_hold;
    pump_on_out && !ctrl_wr && !auto_q;
  endsequence
  // ====
  // Assertions
  chk_rdata_quiet: assert property (!$past(bus_in.rd) |-> rdata_out == 8'h00)
    else $error("read data without a read");
  chk_reset_clean: assert property ($rose(nrst_in) |-> !pump_on_out && !power_down_out)
    else $error("outputs not clear after reset");
  chk_pump_cause: assert property ($rose(pump_on_out) |-> $past(start_req))
    else $error("pump started without a valid start");
  chk_pump_stop: assert property (s_stop_req |=> !pump_on_out)
    else $error("pump kept after stop write");
  chk_pump_holds: assert property (s_idle_hold |=> pump_on_out)
    else $error("manual cycle ended by itself");
  chk_auto_length: assert property ($fell(pump_on_out) && !$past(ctrl_wr) |-> on_cnt >= AUTO_MIN)
    else $error("timed cycle too short");
  chk_off_cause: assert property ($changed(power_down_out) |->
      $past(ctrl_wr) && (power_down_out == $past(bus_in.wdata[5])))
    else $error("power down changed without control write");
  chk_latch_kept: assert property ($past(ctrl_rd_on) |-> rdata_out[2])
    else $error("latch read clear while pump on");
endmodule
bind epc_ctrl epc_ctrl_checker epc_ctrl_checker_i (
  .clk_in(clk_in), .nrst_in(nrst_in), .por_n_in(por_n_in), .ref_sel_in(ref_sel_in),
  .ref_clk_in(ref_clk_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .pump_on_out(pump_on_out), .power_down_out(power_down_out));

// File: tb/epc_xtal.sv
// Crystal reference clock source feeding the timebase pin
`timescale 1ns/1ps
module epc_xtal #(
  parameter int HALF_NS = 150
) (
  input  wire logic run_in,
  output logic      ref_clk_out
);
  // Parked low when disabled so a stale edge never reaches the timebase
  initial
  begin
    ref_clk_out = 1'b0;
    // Offset keeps pin edges clear of bus clock edges, avoiding a sampling race
    #25;
    forever
    begin
      #(HALF_NS);
      ref_clk_out = run_in ? !ref_clk_out : 1'b0;
    end
  end
endmodule

// File: tb/test_epc_ctrl.sv
// Self-checking bench for the EEPROM program/erase controller
`timescale 1ns/1ps
`include "epc_defs.svh"
module test_epc_ctrl;
  import epc_pkg::*;
  logic       clk_in;
  logic       nrst_in;
  logic       por_n_in;
  logic       ref_sel_in;
  logic       ref_clk;
  logic       xtal_run;
  epc_req_t   bus;
  logic [7:0] rdata;
  logic       pump;
  logic       pdown;
  int         err_count;
  int         num_checks;
  int         cycles;
  int         n;
  logic [7:0] v;
  epc_ctrl epc_ctrl_i (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .por_n_in(por_n_in),
    .ref_sel_in(ref_sel_in),
    .ref_clk_in(ref_clk),
    .bus_in(bus),
    .rdata_out(rdata),
    .pump_on_out(pump),
    .power_down_out(pdown));
  epc_xtal epc_xtal_i (.run_in(xtal_run), .ref_clk_out(ref_clk));
  // ====
  // Clock and hang guard
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = !clk_in;
  end
  // Whole run needs about fifteen hundred cycles; far beyond that means a hang
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      stop_test();
    end
  end
  // ====
  // Bus and check tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobe dropped one edge later, so back-to-back calls never collide
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus <= '0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus <= '0;
    #1;
    d = rdata;
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic rst(input logic por);
    @(posedge clk_in);
    nrst_in  <= 1'b0;
    por_n_in <= !por;
    repeat (2) @(posedge clk_in);
    nrst_in  <= 1'b1;
    por_n_in <= 1'b1;
  endtask
  // Full operation; timed ones poll prog_en, manual ones stop by hand
  task automatic op(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] d);
    n = 0;
    v = 8'h01;
    wr(`EPC_ADDR_CTRL, ctl | 8'h04);
    wr(a, d);
    wr(`EPC_ADDR_CTRL, ctl | 8'h05);
    if (ctl[1])
      while (v[0] && n < 1500)
      begin
        rd(`EPC_ADDR_CTRL, v);
        n++;
      end
    else
      repeat (3) @(posedge clk_in);
    wr(`EPC_ADDR_CTRL, 8'h00);
    wr(`EPC_ADDR_CTRL, 8'h00);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // ====
  // Scenarios
  task automatic t_reset_vals();
    rc(`EPC_ADDR_CTRL, 8'h00);
    rc(`EPC_ADDR_ACFG, 8'hf0);
    rc(`EPC_ADDR_DIVH, 8'h80);
    rc(`EPC_ADDR_DIVL, 8'h01);
    rc(16'h0100, 8'h00);
    rc(16'h0800, 8'hff);
    done("reset_vals");
  endtask
  task automatic t_divider();
    // Bus clock divisor: 10 MHz x 35 us + 0.5, floored, gives 350
    wr(`EPC_ADDR_DIVH, 8'h81);
    wr(`EPC_ADDR_DIVL, 8'h5e);
    rc(`EPC_ADDR_DIVH, 8'h81);
    rc(`EPC_ADDR_DIVL, 8'h5e);
    // Divisor of zero until t_refclk keeps timed cycles short
    wr(`EPC_ADDR_DIVH, 8'h80);
    wr(`EPC_ADDR_DIVL, 8'h00);
    rc(`EPC_ADDR_DIVL, 8'h00);
    wr(`EPC_ADDR_CTRL, 8'h04);
    wr(`EPC_ADDR_DIVL, 8'h55);
    rc(`EPC_ADDR_DIVL, 8'h00);
    wr(`EPC_ADDR_CTRL, 8'h00);
    done("divider");
  endtask
  task automatic t_refused();
    wr(`EPC_ADDR_CTRL, 8'h01);
    rc(`EPC_ADDR_CTRL, 8'h00);
    wr(`EPC_ADDR_CTRL, 8'h04);
    wr(16'h0100, 8'h00);
    wr(`EPC_ADDR_CTRL, 8'h05);
    chk({7'h00, pump}, 8'h00);
    wr(`EPC_ADDR_CTRL, 8'h00);
    done("refused");
  endtask
  task automatic t_program();
    wr(`EPC_ADDR_CTRL, 8'h04);
    wr(16'h0800, 8'h5a);
    wr(16'h0801, 8'ha5);
    rc(16'h0801, 8'ha5);
    wr(`EPC_ADDR_CTRL, 8'h05);
    chk({7'h00, pump}, 8'h01);
    wr(`EPC_ADDR_CTRL, 8'h00);
    chk({7'h00, pump}, 8'h00);
    rc(`EPC_ADDR_CTRL, 8'h04);
    wr(`EPC_ADDR_CTRL, 8'h00);
    rc(16'h0801, 8'ha5);
    rc(16'h0800, 8'hff);
    done("program");
  endtask
  task automatic t_auto();
    op(8'h0a, 16'h0801, 8'h00);
    chk((n >= 140 && n < 1500) ? 8'h01 : 8'h00, 8'h01);
    chk(v, 8'h0e);
    rc(16'h0801, 8'hff);
    done("auto");
  endtask
  // Array read while the pump runs must spoil the cycle and flag it
  task automatic t_disturb();
    wr(`EPC_ADDR_CTRL, 8'h04);
    wr(16'h0804, 8'h00);
    wr(`EPC_ADDR_CTRL, 8'h05);
    rc(16'h0804, 8'h00);
    wr(`EPC_ADDR_CTRL, 8'h00);
    wr(`EPC_ADDR_CTRL, 8'h00);
    rc(`EPC_ADDR_STAT, 8'h02);
    rc(16'h0804, 8'hff);
    wr(`EPC_ADDR_STAT, 8'h02);
    rc(`EPC_ADDR_STAT, 8'h00);
    done("disturb");
  endtask
  task automatic t_modes();
    op(8'h00, 16'h0880, 8'h00);
    op(8'h00, 16'h0900, 8'h0f);
    op(8'h10, 16'h0881, 8'h33);
    rc(16'h0880, 8'hff);
    rc(16'h0900, 8'h0f);
    op(8'h18, 16'h09ff, 8'h00);
    rc(16'h0900, 8'hff);
    done("modes");
  endtask
  task automatic t_refclk();
    wr(`EPC_ADDR_DIVL, 8'h01);
    @(posedge clk_in);
    ref_sel_in <= 1'b1;
    xtal_run   <= 1'b1;
    op(8'h02, 16'h0802, 8'h0f);
    chk((n >= 300 && n < 1500) ? 8'h01 : 8'h00, 8'h01);
    rc(16'h0802, 8'h0f);
    @(posedge clk_in);
    ref_sel_in <= 1'b0;
    xtal_run   <= 1'b0;
    done("refclk");
  endtask
  task automatic t_off();
    wr(`EPC_ADDR_CTRL, 8'h20);
    chk({7'h00, pdown}, 8'h01);
    wr(`EPC_ADDR_CTRL, 8'h24);
    wr(16'h0803, 8'h00);
    wr(`EPC_ADDR_CTRL, 8'h25);
    chk({7'h00, pump}, 8'h00);
    rst(1'b0);
    chk({7'h00, pdown}, 8'h00);
    rc(`EPC_ADDR_CTRL, 8'h00);
    done("array_off");
  endtask
  task automatic t_protect();
    op(8'h08, `EPC_ADDR_ACFG_NV, 8'h00);
    rc(`EPC_ADDR_ACFG_NV, 8'hff);
    rc(`EPC_ADDR_ACFG, 8'hff);
    op(8'h00, 16'h0980, 8'h00);
    rc(16'h0980, 8'hff);
    op(8'h00, `EPC_ADDR_ACFG_NV, 8'he1);
    rc(`EPC_ADDR_ACFG_NV, 8'he1);
    rst(1'b0);
    rc(`EPC_ADDR_ACFG, 8'he1);
    op(8'h00, 16'h0810, 8'h00);
    rc(16'h0810, 8'hff);
    op(8'h00, 16'h08f0, 8'h00);
    rc(16'h08f0, 8'hff);
    op(8'h00, 16'h0910, 8'h00);
    rc(16'h0910, 8'h00);
    op(8'h10, 16'h0910, 8'h00);
    rc(16'h0910, 8'h00);
    op(8'h08, 16'h0910, 8'h00);
    rc(16'h0910, 8'hff);
    op(8'h08, `EPC_ADDR_ACFG_NV, 8'h00);
    rc(`EPC_ADDR_ACFG_NV, 8'he1);
    done("protect");
  endtask
  task automatic t_divlock();
    wr(`EPC_ADDR_DIVH, 8'h00);
    rc(`EPC_ADDR_DIVH, 8'h00);
    wr(`EPC_ADDR_DIVH, 8'h80);
    wr(`EPC_ADDR_DIVL, 8'h33);
    rc(`EPC_ADDR_DIVH, 8'h00);
    rc(`EPC_ADDR_DIVL, 8'h01);
    op(8'h08, `EPC_ADDR_DIVL_NV, 8'h00);
    rc(`EPC_ADDR_DIVL_NV, 8'h01);
    rst(1'b0);
    rc(`EPC_ADDR_DIVH, 8'h80);
    done("divlock");
  endtask
  // ====
  // Main sequence and verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    err_count  = 0;
    num_checks = 0;
    cycles     = 0;
    bus        = '0;
    nrst_in    = 1'b0;
    por_n_in   = 1'b0;
    ref_sel_in = 1'b0;
    xtal_run   = 1'b0;
    rst(1'b1);
    t_reset_vals();
    t_divider();
    t_refused();
    t_program();
    t_auto();
    t_disturb();
    t_modes();
    t_refclk();
    t_off();
    t_protect();
    t_divlock();
    stop_test();
  end
endmodule
